// *** ecp_pkg.sv ***
// register map, field layout and encodings of the event counter
package ecp_pkg;
  localparam logic [7:0] ADDR_MOD_CNT = 8'h00;
  localparam logic [7:0] ADDR_WIDTH_CMP = 8'h04;
  localparam logic [7:0] ADDR_SKEW_CMP = 8'h08;
  localparam logic [7:0] ADDR_ACC_CNT = 8'h0c;
  localparam logic [7:0] ADDR_PHASE_CMP = 8'h10;
  localparam logic [7:0] ADDR_ACC_EVT_CMP = 8'h14;
  localparam logic [7:0] ADDR_MODE_REG = 8'h18;
  localparam logic [7:0] ADDR_CTL_REG = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // mode register fields
  localparam int MODE_LO_BIT = 0;
  localparam int MODE_HI_BIT = 1;
  localparam int SEL1_LSB = 2;
  localparam int SEL1_MSB = 4;
  localparam int SEL2_LSB = 5;
  localparam int SEL2_MSB = 6;
  localparam int PRESC_LSB = 8;
  localparam int PRESC_MSB = 10;
  // control register fields
  localparam int POL_BIT = 0;
  localparam int OEN_BIT = 1;
  localparam int IEN1_BIT = 2;
  localparam int IEN2_BIT = 3;
  // status register fields, write one to clear
  localparam int EV1_BIT = 0;
  localparam int EV2_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  typedef enum logic [1:0] {
    MODE_PHASE = 2'b00,
    MODE_INDEP = 2'b01,
    MODE_PERIOD = 2'b10,
    MODE_PRESC = 2'b11
  } ecp_mode_e;
  // first selector encodings (bit c, b, a)
  localparam logic [2:0] SEL1_OFF = 3'h0;
  localparam logic [2:0] SEL1_PASS = 3'h1;
  localparam logic [2:0] SEL1_GATE_HI = 3'h2;
  localparam logic [2:0] SEL1_GATE_LO = 3'h3;
  localparam logic [2:0] SEL1_RISE = 3'h4;
  localparam logic [2:0] SEL1_FALL = 3'h5;
  localparam logic [2:0] SEL1_BOTH = 3'h6;
  localparam logic [2:0] SEL1_PRESC = 3'h7;
  // second selector encodings
  localparam logic [1:0] SEL2_OFF = 2'h0;
  localparam logic [1:0] SEL2_RISE = 2'h1;
  localparam logic [1:0] SEL2_FALL = 2'h2;
  localparam logic [1:0] SEL2_HIGH = 2'h3;
endpackage

// *** ecp_event_counter.sv ***
// event counter: pulse accumulator and phase-shift modulator with apb registers
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module ecp_event_counter
  import ecp_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // event pins
  input wire logic FIRST_EVENT_IN,
  input wire logic SECOND_EVENT_IN,
  output logic EVENT_OUT,
  output logic EVENT_OE_OUT,
  // pin ownership, low means general I/O
  output logic FIRST_PIN_USED_OUT,
  output logic SECOND_PIN_USED_OUT,
  // enabled event requests
  output logic FIRST_EVENT_IRQ_OUT,
  output logic SECOND_EVENT_IRQ_OUT
);
  localparam int PIN_COUNT = 2;
  localparam int FIRST_PIN = 0;
  localparam int SECOND_PIN = 1;
  // counters
  logic [7:0] mod_cnt_q;
  logic [7:0] acc_cnt_q;
  // compare registers
  logic [7:0] width_cmp_q;
  logic [7:0] skew_cmp_q;
  logic [7:0] phase_cmp_q;
  logic [7:0] acc_evt_cmp_q;
  // control state
  logic [10:0] mode_reg_q;
  logic [3:0] ctl_q;
  // sticky event flags and raw output level
  logic ev1_q;
  logic ev2_q;
  logic out_q;
  // pin synchronisers and edge history
  logic sync_a_q [PIN_COUNT];
  logic sync_b_q [PIN_COUNT];
  logic prev_q [PIN_COUNT];
  wire [PIN_COUNT-1:0] pin_raw = {SECOND_EVENT_IN, FIRST_EVENT_IN};
  logic [7:0] tb_q;
  logic [31:0] rdata_d;

  function automatic logic is_gate(input logic [2:0] sel);
    is_gate = (sel == SEL1_GATE_HI) || (sel == SEL1_GATE_LO);
  endfunction
  function automatic logic is_edge1(input logic [2:0] sel);
    is_edge1 = (sel == SEL1_RISE) || (sel == SEL1_FALL) || (sel == SEL1_BOTH);
  endfunction

  // bus decode
  wire acc_phase = PSEL_IN && PENABLE_IN;
  wire wr = acc_phase && PWRITE_IN;
  wire hit_mod = PADDR_IN == ADDR_MOD_CNT;
  wire hit_wid = PADDR_IN == ADDR_WIDTH_CMP;
  wire hit_skw = PADDR_IN == ADDR_SKEW_CMP;
  wire hit_acc = PADDR_IN == ADDR_ACC_CNT;
  wire hit_phs = PADDR_IN == ADDR_PHASE_CMP;
  wire hit_aev = PADDR_IN == ADDR_ACC_EVT_CMP;
  wire hit_mode = PADDR_IN == ADDR_MODE_REG;
  wire hit_ctl = PADDR_IN == ADDR_CTL_REG;
  wire hit_st = PADDR_IN == ADDR_STATUS;
  wire hit_any = hit_mod | hit_wid | hit_skw | hit_acc | hit_phs | hit_aev | hit_mode | hit_ctl | hit_st;

  // per-register write strobes
  wire wr_mod = wr && hit_mod;
  wire wr_wid = wr && hit_wid;
  wire wr_skw = wr && hit_skw;
  wire wr_acc = wr && hit_acc;
  wire wr_phs = wr && hit_phs;
  wire wr_aev = wr && hit_aev;
  wire wr_mode = wr && hit_mode;
  wire wr_ctl = wr && hit_ctl;
  wire wr_st = wr && hit_st;

  // mode and selectors
  wire ecp_mode_e mode = ecp_mode_e'({mode_reg_q[MODE_HI_BIT], mode_reg_q[MODE_LO_BIT]});
  wire [2:0] sel1 = mode_reg_q[SEL1_MSB:SEL1_LSB];
  wire [1:0] sel2 = mode_reg_q[SEL2_MSB:SEL2_LSB];
  wire [2:0] presc = mode_reg_q[PRESC_MSB:PRESC_LSB];
  wire pin1 = sync_b_q[FIRST_PIN];
  wire pin2 = sync_b_q[SECOND_PIN];
  wire rise1 = pin1 && !prev_q[FIRST_PIN];
  wire fall1 = !pin1 && prev_q[FIRST_PIN];
  wire rise2 = pin2 && !prev_q[SECOND_PIN];
  wire fall2 = !pin2 && prev_q[SECOND_PIN];

  // time base: E is the system clock, scaled E is E divided by 2^presc
  wire [7:0] tb_next = tb_q + ONE_BYTE;
  wire [7:0] scale_mask = (ONE_BYTE << presc) - ONE_BYTE;
  wire scaled_tick = (tb_q & scale_mask) == scale_mask;

  // first selector tick
  wire gated = (sel1 == SEL1_GATE_HI && pin1) || (sel1 == SEL1_GATE_LO && !pin1);
  wire tick1 = (sel1 == SEL1_PASS) ? 1'b1 :
               is_gate(sel1) ? (scaled_tick && !gated) :
               (sel1 == SEL1_RISE) ? rise1 :
               (sel1 == SEL1_FALL) ? fall1 :
               (sel1 == SEL1_BOTH) ? (rise1 || fall1) :
               (sel1 == SEL1_PRESC) ? scaled_tick : 1'b0;
  // second selector: clear event in mode 0, clock in mode 1
  wire sel2_hit = (sel2 == SEL2_RISE) ? rise2 :
                  (sel2 == SEL2_FALL) ? fall2 :
                  (sel2 == SEL2_HIGH) ? pin2 : 1'b0;
  wire tick2 = (sel2 == SEL2_HIGH) ? !pin2 : sel2_hit; // high level gates E in mode 1

  // counter matches
  wire width_match = mod_cnt_q == width_cmp_q;
  wire skew_match = mod_cnt_q == skew_cmp_q;
  wire phase_match = acc_cnt_q == phase_cmp_q;
  wire acc_evt_match = acc_cnt_q == acc_evt_cmp_q;
  wire is_m0 = mode == MODE_PHASE;

  // accumulator clock and clear per mode
  wire acc_clear_pin = is_m0 && sel2_hit;
  wire acc_tick = is_m0 ? tick1 :
                  (mode == MODE_INDEP) ? tick2 :
                  (mode == MODE_PERIOD) ? (tick1 && width_match) :
                  tick1;
  wire acc_wrap = !is_m0 && acc_tick && phase_match;
  // modulator clock and clear per mode
  wire mod_tick = (mode == MODE_PRESC) ? acc_wrap : tick1;
  wire mod_period_end = !is_m0 && mod_tick && width_match;
  wire mod_clear = is_m0 ? ((tick1 && phase_match) || (acc_clear_pin && phase_cmp_q == RESET_BYTE))
                         : mod_period_end;
  wire acc_evt = acc_tick && acc_evt_match;
  wire width_evt = mod_tick && width_match;

  wire [7:0] acc_cnt_d = wr_acc ? PWDATA_IN[7:0] :
                         (acc_clear_pin || acc_wrap) ? RESET_BYTE :
                         acc_tick ? acc_cnt_q + ONE_BYTE : acc_cnt_q;
  wire [7:0] mod_cnt_d = wr_mod ? PWDATA_IN[7:0] :
                         mod_clear ? RESET_BYTE :
                         mod_tick ? mod_cnt_q + ONE_BYTE : mod_cnt_q;
  // output raw level: set on skew match, reset on width match; reset wins
  wire out_d = (mod_tick && width_match) ? 1'b0 :
               (mod_tick && skew_match) ? 1'b1 : out_q;
  wire ev1_clr = wr_st && PWDATA_IN[EV1_BIT];
  wire ev2_clr = wr_st && PWDATA_IN[EV2_BIT];
  wire ev1_d = width_evt || (ev1_q && !ev1_clr);
  wire ev2_d = acc_evt || (ev2_q && !ev2_clr);

  // next values of the registered outputs
  wire pol_level = out_d ^ ctl_q[POL_BIT];
  wire pin1_used = is_gate(sel1) || is_edge1(sel1);
  wire pin2_used = sel2 != SEL2_OFF;
  wire irq1_d = ev1_d && ctl_q[IEN1_BIT];
  wire irq2_d = ev2_d && ctl_q[IEN2_BIT];
  wire ready_d = acc_phase && !PREADY_OUT;
  wire slverr_d = ready_d && !hit_any;

  always_comb begin
    rdata_d = RESET_WORD;
    if (hit_mod) rdata_d[7:0] = mod_cnt_q;
    if (hit_wid) rdata_d[7:0] = width_cmp_q;
    if (hit_skw) rdata_d[7:0] = skew_cmp_q;
    if (hit_acc) rdata_d[7:0] = acc_cnt_q;
    if (hit_phs) rdata_d[7:0] = phase_cmp_q;
    if (hit_aev) rdata_d[7:0] = acc_evt_cmp_q;
    if (hit_mode) rdata_d[10:0] = mode_reg_q;
    if (hit_ctl) rdata_d[3:0] = ctl_q;
    if (hit_st) rdata_d[1:0] = {ev2_q, ev1_q};
  end

  // two-flop synchronisers; the first stage feeds only the second
  for (genvar k = 0; k < PIN_COUNT; k++) begin : g_pin_sync
    always_ff @(posedge CLK_IN) begin
      sync_a_q[k] <= pin_raw[k];
      sync_b_q[k] <= sync_a_q[k];
    end

    // history reset to the idle low level so no false edge follows reset
    always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
        prev_q[k] <= 1'b0;
      end else begin
        prev_q[k] <= sync_b_q[k];
      end
    end
  end

  // free-running time base for the scaled taps
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      tb_q <= RESET_BYTE;
    end else begin
      tb_q <= tb_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      mod_cnt_q <= RESET_BYTE;
    end else begin
      mod_cnt_q <= mod_cnt_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      acc_cnt_q <= RESET_BYTE;
    end else begin
      acc_cnt_q <= acc_cnt_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // set beats clear when both fall in one cycle
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ev1_q <= 1'b0;
    end else begin
      ev1_q <= ev1_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ev2_q <= 1'b0;
    end else begin
      ev2_q <= ev2_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      width_cmp_q <= RESET_BYTE;
    end else if (wr_wid) begin
      width_cmp_q <= PWDATA_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      skew_cmp_q <= RESET_BYTE;
    end else if (wr_skw) begin
      skew_cmp_q <= PWDATA_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      phase_cmp_q <= RESET_BYTE;
    end else if (wr_phs) begin
      phase_cmp_q <= PWDATA_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      acc_evt_cmp_q <= RESET_BYTE;
    end else if (wr_aev) begin
      acc_evt_cmp_q <= PWDATA_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      mode_reg_q <= '0;
    end else if (wr_mode) begin
      mode_reg_q <= PWDATA_IN[10:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ctl_q <= '0;
    end else if (wr_ctl) begin
      ctl_q <= PWDATA_IN[3:0];
    end
  end

  // registered outputs; one-cycle apb answer
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT <= RESET_WORD;
    end else begin
      PRDATA_OUT <= rdata_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PREADY_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= ready_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PSLVERR_OUT <= 1'b0;
    end else begin
      PSLVERR_OUT <= slverr_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      EVENT_OUT <= 1'b0;
    end else begin
      EVENT_OUT <= pol_level;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      EVENT_OE_OUT <= 1'b0;
    end else begin
      EVENT_OE_OUT <= ctl_q[OEN_BIT];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      FIRST_PIN_USED_OUT <= 1'b0;
    end else begin
      FIRST_PIN_USED_OUT <= pin1_used;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      SECOND_PIN_USED_OUT <= 1'b0;
    end else begin
      SECOND_PIN_USED_OUT <= pin2_used;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      FIRST_EVENT_IRQ_OUT <= 1'b0;
    end else begin
      FIRST_EVENT_IRQ_OUT <= irq1_d;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      SECOND_EVENT_IRQ_OUT <= 1'b0;
    end else begin
      SECOND_EVENT_IRQ_OUT <= irq2_d;
    end
  end
endmodule // ecp_event_counter

// *** ecp_event_counter_assertions.sv ***
// port assertions of the event counter
`timescale 1ns/100ps
module ecp_event_counter_assertions (
  // clock, reset and apb
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // pins and requests
  input wire logic EVENT_OE_OUT,
  input wire logic SECOND_PIN_USED_OUT,
  input wire logic FIRST_EVENT_IRQ_OUT,
  input wire logic SECOND_EVENT_IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  wire wr_taken = PSEL_IN && PENABLE_IN && PWRITE_IN;
  sequence s_setup; PSEL_IN && !PENABLE_IN; endsequence
  sequence s_access; s_setup ##1 PSEL_IN && PENABLE_IN; endsequence
  a_ready_answer:
    assert property (s_access |=> PREADY_OUT) else $error("ready missing");
  a_ready_single:
    assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready too long");
  a_err_zero_data:
    assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0) else $error("bad error reply");
  a_upper_zero:
    assert property (PREADY_OUT |-> PRDATA_OUT[31:11] == 21'h0) else $error("upper bits set");
  // outputs owned by registers move, and requests fall, only after a write
  a_oe_by_write:
    assert property ($changed(EVENT_OE_OUT) |-> $past(wr_taken) || $past(wr_taken, 2)) else $error("oe moved");
  a_pin_by_write:
    assert property ($changed(SECOND_PIN_USED_OUT) |-> $past(wr_taken) || $past(wr_taken, 2)) else $error("pin");
  a_irq1_sticky:
    assert property ($fell(FIRST_EVENT_IRQ_OUT) |-> $past(wr_taken) || $past(wr_taken, 2)) else $error("irq1");
  a_irq2_sticky:
    assert property ($fell(SECOND_EVENT_IRQ_OUT) |-> $past(wr_taken) || $past(wr_taken, 2)) else $error("irq2");
endmodule // ecp_event_counter_assertions

// *** ecp_pin_src.sv ***
// pulse source model for the event input pins
`timescale 1ns/100ps
module ecp_pin_src (
  input wire logic clk_in,
  output logic first_out,
  output logic second_out
);
  initial first_out = 1'b0;
  initial second_out = 1'b0;
  task automatic pulse1();
    @(posedge clk_in);
    first_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    first_out <= 1'b0;
  endtask
  task automatic level1(input logic lv);
    @(posedge clk_in);
    first_out <= lv;
  endtask
  // held 4 clocks so the synchroniser sees one clean edge
  task automatic pulse2();
    @(posedge clk_in);
    second_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    second_out <= 1'b0;
  endtask
endmodule // ecp_pin_src

// *** tb_event_counter_phase_pwm.sv ***
// self-checking bench of the event counter
`timescale 1ns/100ps
module tb_event_counter_phase_pwm;
  import ecp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ev_out, ev_oe, irq1, irq2, pin1, pin2, first_in, second_in;
  int fails = 0;
  int compares = 0;
  ecp_event_counter i_dut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .FIRST_EVENT_IN(first_in), .SECOND_EVENT_IN(second_in), .EVENT_OUT(ev_out), .EVENT_OE_OUT(ev_oe),
    .FIRST_PIN_USED_OUT(pin1), .SECOND_PIN_USED_OUT(pin2), .FIRST_EVENT_IRQ_OUT(irq1),
    .SECOND_EVENT_IRQ_OUT(irq2));
  ecp_pin_src i_src (.clk_in(clk), .first_out(first_in), .second_out(second_in));
  initial forever #50 clk = ~clk;
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cfg(logic [1:0] md, logic [2:0] s1, logic [1:0] s2, logic [7:0] ph, logic [7:0] sk, logic [7:0] wd);
    wr(ADDR_MODE_REG, {25'h0, s2, s1, md});
    wr(ADDR_PHASE_CMP, {24'h0, ph});
    wr(ADDR_SKEW_CMP, {24'h0, sk});
    wr(ADDR_WIDTH_CMP, {24'h0, wd});
    wr(ADDR_MOD_CNT, RESET_WORD);
    wr(ADDR_ACC_CNT, RESET_WORD);
  endtask
  // delay from the end of the second-pin pulse to the leading edge, then pulse length
  task automatic burst(output int dly, output int wid);
    dly = 0;
    wid = 0;
    i_src.pulse2();
    while (ev_out !== 1'b1 && dly < 600) begin @(posedge clk); dly++; end
    while (ev_out === 1'b1 && wid < 600) begin @(posedge clk); wid++; end
  endtask
  task automatic t_regs();
    logic [7:0] a [6] = '{ADDR_MOD_CNT, ADDR_WIDTH_CMP, ADDR_SKEW_CMP, ADDR_ACC_CNT, ADDR_PHASE_CMP, ADDR_ACC_EVT_CMP};
    logic [31:0] q;
    logic e;
    foreach (a[i]) begin
      rd(a[i], q);
      check("reset", q, RESET_WORD);
      wr(a[i], 32'hffff_ff50 | 32'(i));
      rd(a[i], q);
      check("readback", q, 32'h50 + 32'(i));
    end
    apb(1'b1, 8'h24, 32'hffff_ffff, q, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    rd(8'h24, q);
    check("unmapped read", q, RESET_WORD);
    $display("t_regs done");
  endtask
  task automatic t_mode0();
    int d1, w1, d2, w2;
    cfg(MODE_PHASE, SEL1_PASS, SEL2_RISE, 8'h04, 8'h02, 8'h06); // skew below width
    wr(ADDR_ACC_EVT_CMP, 32'h3);
    wr(ADDR_CTL_REG, 32'he);
    burst(d1, w1);
    check("width", w1, 4);
    check("irq1", irq1, 1'b1);
    check("irq2", irq2, 1'b1);
    check("oe", {ev_oe, pin2}, 2'b11);
    wr(ADDR_PHASE_CMP, 32'h8);
    burst(d2, w2);
    check("phase", d2 - d1, 4);
    wr(ADDR_SKEW_CMP, 32'h5);
    burst(d1, w1);
    check("skew", d1 - d2, 3);
    check("skew width", w1, 1);
    wr(ADDR_SKEW_CMP, 32'h6);
    burst(d1, w1);
    check("equal low", d1, 600);
    wr(ADDR_CTL_REG, 32'h3);
    wr(ADDR_STATUS, 32'h3);
    check("inverted", {ev_out, irq1, irq2}, 3'b100);
    $display("t_mode0 done");
  endtask
  task automatic t_modes();
    logic [31:0] q;
    cfg(MODE_INDEP, SEL1_PASS, SEL2_OFF, 8'hff, 8'h10, 8'hff);
    cyc(50);
    rd(ADDR_ACC_CNT, q);
    check("indep acc", q, RESET_WORD);
    rd(ADDR_MOD_CNT, q);
    check("indep mod", q > 50 && q < 70, 1'b1);
    check("pass pin free", pin1, 1'b0);
    cfg(MODE_PERIOD, SEL1_PASS, SEL2_OFF, 8'hff, 8'h03, 8'h09);
    cyc(100);
    rd(ADDR_ACC_CNT, q);
    check("periods", q > 8 && q < 13, 1'b1);
    cfg(MODE_PRESC, SEL1_PASS, SEL2_OFF, 8'h03, 8'h10, 8'hff);
    cyc(80);
    rd(ADDR_MOD_CNT, q);
    check("prescaled", q > 17 && q < 25, 1'b1);
    $display("t_modes done");
  endtask
  task automatic t_pins();
    logic [31:0] q;
    cfg(MODE_INDEP, SEL1_RISE, SEL2_RISE, 8'hff, 8'h10, 8'hff);
    repeat (3) i_src.pulse1();
    repeat (2) i_src.pulse2();
    rd(ADDR_MOD_CNT, q);
    check("pin1 rises", q, 32'h3);
    rd(ADDR_ACC_CNT, q);
    check("pin2 rises", q, 32'h2);
    check("pin1 used", pin1, 1'b1);
    i_src.level1(1'b1);
    cfg(MODE_INDEP, SEL1_GATE_HI, SEL2_OFF, 8'hff, 8'h10, 8'hff);
    cyc(20);
    rd(ADDR_MOD_CNT, q);
    check("gate inhibit", q, RESET_WORD);
    i_src.level1(1'b0);
    cyc(20);
    rd(ADDR_MOD_CNT, q);
    check("gate open", q > 15 && q < 30, 1'b1);
    $display("t_pins done");
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_mode0();
    t_modes();
    t_pins();
    final_report();
  end
endmodule // tb_event_counter_phase_pwm
bind ecp_event_counter ecp_event_counter_assertions i_chk (.CLK_IN, .RESET_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
  .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .EVENT_OE_OUT, .SECOND_PIN_USED_OUT, .FIRST_EVENT_IRQ_OUT,
  .SECOND_EVENT_IRQ_OUT);
